/* ufg_pkg.sv */
// Package: constants and types for the ISP user flash guard
package ufg_pkg;
    localparam int IO_W = 8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h1;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h3;
    localparam logic [3:0] OFS_CLAMP_VAL = 4'h4;
    localparam logic [3:0] OFS_IO_OUT = 4'h5;
    localparam logic [3:0] OFS_IO_OE = 4'h6;
    // Control bits
    localparam int CTRL_CLAMP_BIT = 0;
    localparam int CTRL_RTP_BIT = 1;
    // Event bits
    localparam int EV_START_BIT = 0;
    localparam int EV_DONE_BIT = 1;
    localparam int EV_ABORT_BIT = 2;
    localparam int EV_W = 3;
    // TAP instruction codes, 4 bits
    localparam int IR_W = 4;
    localparam logic [3:0] IR_ENTER = 4'h2;
    localparam logic [3:0] IR_PROGRAM = 4'h3;
    localparam logic [3:0] IR_FINISH = 4'h4;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    // Timing: wait before programming
    localparam int CLK_MHZ = 25;
    localparam int RTP_WAIT_MS = 500;
    localparam int RTP_WAIT_CYC = RTP_WAIT_MS * 1000 * CLK_MHZ;
    localparam int WAIT_CNT_W = 24;
    typedef enum logic [3:0] {
        UFG_RESET, UFG_IDLE, UFG_SEL_DR, UFG_CAP_DR, UFG_SH_DR,
        UFG_EX1_DR, UFG_PA_DR, UFG_EX2_DR, UFG_UP_DR, UFG_SEL_IR,
        UFG_CAP_IR, UFG_SH_IR, UFG_EX1_IR, UFG_PA_IR, UFG_EX2_IR,
        UFG_UP_IR
    } ufg_tap_t;
    typedef enum logic [1:0] {
        UFG_USER, UFG_WAITING, UFG_PROGRAMMING
    } ufg_isp_t;
endpackage

/* ufg_guard.sv */
// Module: ISP user flash guard with TAP, busy flag and I/O gating
//
// Overview of operation
// - Busy output high during real-time programming
// - Done flag set only at successful end
// - Outside ISP, I/O drivers off unless done flag set
// - Core-first power: TAP live, no drive
// - IO-first power: TAP inactive, TDO tristate
// - ISP default: pins tristate with pull-up
// - Clamp or real-time option holds fixed levels
// - TMS high keeps TAP in reset
`timescale 1ns/100ps
module ufg_guard #(
    parameter int RTP_WAIT_CYCLES = ufg_pkg::RTP_WAIT_CYC
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic core_supply_ok_i,
    input wire logic io_supply_ok_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output logic realtime_prog_active_o,
    output logic program_complete_flag_o,
    output logic [7:0] io_out_o,
    output logic [7:0] io_oe_o,
    output logic [7:0] io_pullup_o
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic tck_prev_reg;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg <= 5'h0;
            sync2_reg <= 5'h0;
            tck_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {io_supply_ok_i, core_supply_ok_i, tdi_i,
                tms_i, tck_i};
            sync2_reg <= sync1_reg;
            tck_prev_reg <= sync2_reg[0];
        end
    end
    wire tck_s = sync2_reg[0];
    wire tms_s = sync2_reg[1];
    wire tdi_s = sync2_reg[2];
    wire core_ok = sync2_reg[3];
    wire io_ok = sync2_reg[4];
    wire tck_rise = tck_s & ~tck_prev_reg;
    wire tck_fall = ~tck_s & tck_prev_reg;
    // TAP live only with core power; gated by io supply for drive
    wire tap_live = core_ok & io_ok;

    // ------------------------------------------------------------
    // TAP controller
    // ------------------------------------------------------------
    ufg_pkg::ufg_tap_t tap_reg;
    ufg_pkg::ufg_tap_t tap_next;
    always_comb begin
        tap_next = tap_reg;
        unique case (tap_reg)
            ufg_pkg::UFG_RESET: tap_next = tms_s ? ufg_pkg::UFG_RESET
                : ufg_pkg::UFG_IDLE;
            ufg_pkg::UFG_IDLE: tap_next = tms_s ? ufg_pkg::UFG_SEL_DR
                : ufg_pkg::UFG_IDLE;
            ufg_pkg::UFG_SEL_DR: tap_next = tms_s ? ufg_pkg::UFG_SEL_IR
                : ufg_pkg::UFG_CAP_DR;
            ufg_pkg::UFG_CAP_DR: tap_next = tms_s ? ufg_pkg::UFG_EX1_DR
                : ufg_pkg::UFG_SH_DR;
            ufg_pkg::UFG_SH_DR: tap_next = tms_s ? ufg_pkg::UFG_EX1_DR
                : ufg_pkg::UFG_SH_DR;
            ufg_pkg::UFG_EX1_DR: tap_next = tms_s ? ufg_pkg::UFG_UP_DR
                : ufg_pkg::UFG_PA_DR;
            ufg_pkg::UFG_PA_DR: tap_next = tms_s ? ufg_pkg::UFG_EX2_DR
                : ufg_pkg::UFG_PA_DR;
            ufg_pkg::UFG_EX2_DR: tap_next = tms_s ? ufg_pkg::UFG_UP_DR
                : ufg_pkg::UFG_SH_DR;
            ufg_pkg::UFG_UP_DR: tap_next = tms_s ? ufg_pkg::UFG_SEL_DR
                : ufg_pkg::UFG_IDLE;
            ufg_pkg::UFG_SEL_IR: tap_next = tms_s ? ufg_pkg::UFG_RESET
                : ufg_pkg::UFG_CAP_IR;
            ufg_pkg::UFG_CAP_IR: tap_next = tms_s ? ufg_pkg::UFG_EX1_IR
                : ufg_pkg::UFG_SH_IR;
            ufg_pkg::UFG_SH_IR: tap_next = tms_s ? ufg_pkg::UFG_EX1_IR
                : ufg_pkg::UFG_SH_IR;
            ufg_pkg::UFG_EX1_IR: tap_next = tms_s ? ufg_pkg::UFG_UP_IR
                : ufg_pkg::UFG_PA_IR;
            ufg_pkg::UFG_PA_IR: tap_next = tms_s ? ufg_pkg::UFG_EX2_IR
                : ufg_pkg::UFG_PA_IR;
            ufg_pkg::UFG_EX2_IR: tap_next = tms_s ? ufg_pkg::UFG_UP_IR
                : ufg_pkg::UFG_SH_IR;
            ufg_pkg::UFG_UP_IR: tap_next = tms_s ? ufg_pkg::UFG_SEL_DR
                : ufg_pkg::UFG_IDLE;
        endcase
    end
    // Core-first power: TAP moves on edges, outputs stay off
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tap_reg <= ufg_pkg::UFG_RESET;
        end else if (!core_ok) begin
            tap_reg <= ufg_pkg::UFG_RESET;
        end else if (tck_rise) begin
            tap_reg <= tap_next;
        end
    end

    // ------------------------------------------------------------
    // Instruction and bypass shifting
    // ------------------------------------------------------------
    logic [3:0] ir_sh_reg;
    logic [3:0] ir_reg;
    logic byp_reg;
    wire in_sh_ir = tap_reg == ufg_pkg::UFG_SH_IR;
    wire in_sh_dr = tap_reg == ufg_pkg::UFG_SH_DR;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ir_sh_reg <= 4'h0;
            ir_reg <= ufg_pkg::IR_BYPASS;
            byp_reg <= 1'b0;
        end else if (tap_reg == ufg_pkg::UFG_RESET) begin
            ir_reg <= ufg_pkg::IR_BYPASS;
        end else if (tck_rise) begin
            if (tap_reg == ufg_pkg::UFG_CAP_IR) begin
                ir_sh_reg <= 4'h1;
            end else if (in_sh_ir) begin
                ir_sh_reg <= {tdi_s, ir_sh_reg[3:1]};
            end else if (tap_reg == ufg_pkg::UFG_UP_IR) begin
                ir_reg <= ir_sh_reg;
            end
            if (in_sh_dr) begin
                byp_reg <= tdi_s;
            end
        end
    end
    wire upd_ir = tck_rise && tap_reg == ufg_pkg::UFG_UP_IR;
    wire cmd_enter = upd_ir && ir_sh_reg == ufg_pkg::IR_ENTER;
    wire cmd_prog = upd_ir && ir_sh_reg == ufg_pkg::IR_PROGRAM;
    wire cmd_finish = upd_ir && ir_sh_reg == ufg_pkg::IR_FINISH;
    // TDO changes on falling TCK, driven only while shifting
    wire shifting = in_sh_ir | in_sh_dr;
    wire tdo_bit = in_sh_ir ? ir_sh_reg[0] : byp_reg;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_o <= tdo_bit;
            tdo_oe_o <= shifting & tap_live;
        end else if (!tap_live) begin
            tdo_oe_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // ISP sequence: wait, programming, completion
    // ------------------------------------------------------------
    ufg_pkg::ufg_isp_t isp_reg;
    logic [23:0] wait_reg;
    logic done_reg;
    logic [7:0] ctrl_reg;
    wire rtp_en = ctrl_reg[ufg_pkg::CTRL_RTP_BIT];
    wire clamp_en = ctrl_reg[ufg_pkg::CTRL_CLAMP_BIT];
    wire wait_over = wait_reg == 24'h0;
    wire aborted = isp_reg != ufg_pkg::UFG_USER
        && tap_reg == ufg_pkg::UFG_RESET;
    wire finished = isp_reg == ufg_pkg::UFG_PROGRAMMING && cmd_finish;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            isp_reg <= ufg_pkg::UFG_USER;
            wait_reg <= 24'h0;
        end else if (aborted) begin
            isp_reg <= ufg_pkg::UFG_USER;
        end else begin
            unique case (isp_reg)
                ufg_pkg::UFG_USER: if (cmd_enter) begin
                    isp_reg <= ufg_pkg::UFG_WAITING;
                    wait_reg <= rtp_en ? RTP_WAIT_CYCLES[23:0] : 24'h0;
                end
                ufg_pkg::UFG_WAITING: if (!wait_over) begin
                    wait_reg <= wait_reg - 24'h1;
                end else if (cmd_prog) begin
                    isp_reg <= ufg_pkg::UFG_PROGRAMMING;
                end
                ufg_pkg::UFG_PROGRAMMING: if (cmd_finish) begin
                    isp_reg <= ufg_pkg::UFG_USER;
                end
            endcase
        end
    end
    // Done cleared on entry so a broken run never drives pins
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_reg <= 1'b0;
        end else if (finished) begin
            done_reg <= 1'b1;
        end else if (cmd_enter) begin
            done_reg <= 1'b0;
        end
    end
    wire in_isp = isp_reg != ufg_pkg::UFG_USER;
    // Busy from entry to finish in real-time mode, so user logic stops
    wire busy_next = in_isp & rtp_en;

    // ------------------------------------------------------------
    // Registers and I/O
    // ------------------------------------------------------------
    logic [7:0] clamp_reg;
    logic [7:0] uout_reg;
    logic [7:0] uoe_reg;
    logic [2:0] ist_reg;
    logic [2:0] imask_reg;
    wire [2:0] ev = {aborted, finished, cmd_enter && !in_isp};
    wire wr_ctrl = wr_i && addr_i == ufg_pkg::OFS_CTRL;
    wire wr_ist = wr_i && addr_i == ufg_pkg::OFS_IRQ_STAT;
    // Set wins over write-one-clear
    wire [2:0] ist_next = ev | (ist_reg & ~(wr_ist ? wdata_i[2:0] : 3'h0));
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= 8'h0;
            clamp_reg <= 8'h0;
            uout_reg <= 8'h0;
            uoe_reg <= 8'h0;
            imask_reg <= 3'h0;
            ist_reg <= 3'h0;
        end else begin
            ist_reg <= ist_next;
            if (wr_ctrl && !in_isp) ctrl_reg <= wdata_i;
            if (wr_i && addr_i == ufg_pkg::OFS_CLAMP_VAL) begin
                clamp_reg <= wdata_i;
            end
            if (wr_i && addr_i == ufg_pkg::OFS_IO_OUT) uout_reg <= wdata_i;
            if (wr_i && addr_i == ufg_pkg::OFS_IO_OE) uoe_reg <= wdata_i;
            if (wr_i && addr_i == ufg_pkg::OFS_IRQ_MASK) begin
                imask_reg <= wdata_i[2:0];
            end
        end
    end
    wire hold_fixed = clamp_en | rtp_en;
    wire [7:0] oe_next = in_isp ? (hold_fixed ? 8'hFF : 8'h00)
        : (done_reg ? uoe_reg : 8'h00);
    wire [7:0] out_next = in_isp ? clamp_reg : uout_reg;
    wire [7:0] pu_next = (in_isp && !hold_fixed) ? 8'hFF : 8'h00;
    wire [7:0] stat = {3'h0, io_ok, core_ok, done_reg, busy_next, in_isp};
    wire [7:0] rd_mux =
        addr_i == ufg_pkg::OFS_CTRL ? ctrl_reg :
        addr_i == ufg_pkg::OFS_STAT ? stat :
        addr_i == ufg_pkg::OFS_IRQ_STAT ? {5'h0, ist_reg} :
        addr_i == ufg_pkg::OFS_IRQ_MASK ? {5'h0, imask_reg} :
        addr_i == ufg_pkg::OFS_CLAMP_VAL ? clamp_reg :
        addr_i == ufg_pkg::OFS_IO_OUT ? uout_reg :
        addr_i == ufg_pkg::OFS_IO_OE ? uoe_reg : 8'h00;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h0;
            irq_o <= 1'b0;
            realtime_prog_active_o <= 1'b0;
            program_complete_flag_o <= 1'b0;
            io_out_o <= 8'h0;
            io_oe_o <= 8'h0;
            io_pullup_o <= 8'h0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
            irq_o <= |(ist_next & imask_reg);
            realtime_prog_active_o <= busy_next;
            program_complete_flag_o <= done_reg;
            io_out_o <= out_next;
            io_oe_o <= io_ok ? oe_next : 8'h00;
            io_pullup_o <= pu_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_tms_holds_reset: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        tap_reg == ufg_pkg::UFG_RESET && tms_s && core_ok
        |=> tap_reg == ufg_pkg::UFG_RESET)
        else $error("TAP left reset with TMS high");
    chk_io_off_undone: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !done_reg && !in_isp |=> io_oe_o == 8'h00)
        else $error("I/O driven before done");
    chk_done_only_finish: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        $rose(done_reg) |-> $past(finished))
        else $error("Done set outside finish");
    chk_busy_follows: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        in_isp && rtp_en |=> realtime_prog_active_o)
        else $error("Busy not raised");
    chk_busy_drops: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        finished |=> ##1 !realtime_prog_active_o)
        else $error("Busy not dropped");
    chk_isp_pullup: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        in_isp && !hold_fixed |=> io_oe_o == 8'h00 && io_pullup_o == 8'hFF)
        else $error("Pins not tristated with pull-up");
    chk_clamp_level: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        in_isp && hold_fixed && io_ok |=> io_out_o == $past(clamp_reg))
        else $error("Clamp level wrong");
    chk_tdo_off_io: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !core_ok |=> ##1 !tdo_oe_o)
        else $error("TDO driven without core power");
    chk_no_prog_early: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        isp_reg == ufg_pkg::UFG_WAITING && !wait_over
        |=> isp_reg != ufg_pkg::UFG_PROGRAMMING)
        else $error("Programming before wait");
    chk_tdo_needs_io: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !io_ok |=> !tdo_oe_o)
        else $error("TDO driven without io power");
    chk_abort_no_done: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        aborted |=> !done_reg)
        else $error("Done set by aborted session");
    chk_busy_idle_low: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !in_isp |=> !realtime_prog_active_o)
        else $error("Busy high outside a session");
    cov_io_first: cover property (@(posedge clock_i) io_ok && !core_ok);
    cov_enter: cover property (@(posedge clock_i) cmd_enter);
    cov_finish: cover property (@(posedge clock_i) finished);
    cov_abort: cover property (@(posedge clock_i) aborted);
    cov_rtp: cover property (@(posedge clock_i) realtime_prog_active_o);
endmodule

/* ufg_host.sv */
// Programming host model driving the scan port pins
`timescale 1ns/100ps
module ufg_host (
    input wire logic clock_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    // ------------------------------------------------------------
    // Pin driving
    // ------------------------------------------------------------
    // Powered up with TCK low, TMS high: every port parked in reset
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // One TCK period of 8 system clocks, 320 ns
    task automatic step(input logic tms, input logic tdi);
        @(posedge clock_i);
        tck_o <= 1'b0;
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (4) @(posedge clock_i);
        tck_o <= 1'b1;
        repeat (3) @(posedge clock_i);
    endtask
    // Clock stands low between frames; TDI back to its pull-up level
    task automatic park();
        @(posedge clock_i);
        tck_o <= 1'b0;
        tms_o <= 1'b1;
        tdi_o <= 1'b1;
    endtask
    // Five TMS-high edges reach reset, then settle in idle
    task automatic tap_reset();
        repeat (5) step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        park();
    endtask
    // Whole instruction frame from idle, never cut short
    task automatic load_ir(input logic [3:0] code);
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            step(i == 3, code[i]);
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        park();
    endtask
endmodule

/* test_isp_user_flash_guard.sv */
// Self-checking testbench for the ISP user flash guard
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("mismatch at %0t: got %h want %h", $time, got, exp); \
    end \
end
module test_isp_user_flash_guard;
    localparam int WAIT_SIM = 20;
    logic clock_i;
    logic reset_n_i;
    logic tck_i;
    logic tms_i;
    logic tdi_i;
    logic tdo_o;
    logic tdo_oe_o;
    logic core_supply_ok_i;
    logic io_supply_ok_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] rdata_o;
    logic irq_o;
    logic realtime_prog_active_o;
    logic program_complete_flag_o;
    logic [7:0] io_out_o;
    logic [7:0] io_oe_o;
    logic [7:0] io_pullup_o;
    logic [7:0] uout;
    logic [7:0] uoe;
    logic [7:0] clamp;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    int oe_hits = 0;
    int one_hits = 0;
    int seed = 88658;

    ufg_guard #(.RTP_WAIT_CYCLES(WAIT_SIM)) ufg_guard_inst (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .tck_i(tck_i),
        .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .core_supply_ok_i(core_supply_ok_i),
        .io_supply_ok_i(io_supply_ok_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .realtime_prog_active_o(realtime_prog_active_o),
        .program_complete_flag_o(program_complete_flag_o),
        .io_out_o(io_out_o), .io_oe_o(io_oe_o), .io_pullup_o(io_pullup_o));
    ufg_host ufg_host_inst (.clock_i(clock_i), .tck_o(tck_i),
        .tms_o(tms_i), .tdi_o(tdi_i));

    // ------------------------------------------------------------
    // Clock, watchdog and bus tasks
    // ------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // Counts TDO drive cycles; ceiling far above the ~1090 needed
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (tdo_oe_o === 1'b1) oe_hits <= oe_hits + 1;
        if (tdo_oe_o === 1'b1 && tdo_o === 1'b1) one_hits <= one_hits + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    // Read data exists only in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        `CHK(rdata_o, exp);
    endtask
    task automatic settle();
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        reset_n_i = 1'b0;
        core_supply_ok_i = 1'b1;
        io_supply_ok_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        uout = 8'($random(seed));
        // Never zero, so the done gating is visible on the enables
        uoe = 8'($random(seed)) | 8'h01;
        clamp = 8'($random(seed));
        repeat (12) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(negedge clock_i);
        `CHK(program_complete_flag_o, 1'b0);
        rdc(ufg_pkg::OFS_CTRL, 8'h00);
        rdc(ufg_pkg::OFS_STAT, 8'h18);
        rdc(4'hB, 8'h00);
        wr(ufg_pkg::OFS_IO_OUT, uout);
        wr(ufg_pkg::OFS_IO_OE, uoe);
        settle();
        `CHK(io_oe_o, 8'h00);
        // Random TDI with TMS high must not leave reset
        for (int i = 0; i < 8; i++) begin
            ufg_host_inst.step(1'b1, 1'($random(seed)));
        end
        ufg_host_inst.park();
        rdc(ufg_pkg::OFS_STAT, 8'h18);
        rdc(ufg_pkg::OFS_IRQ_STAT, 8'h00);
        ufg_host_inst.tap_reset();
        // Default session; no flash erase or write in flight
        oe_hits = 0;
        one_hits = 0;
        ufg_host_inst.load_ir(ufg_pkg::IR_ENTER);
        settle();
        // Four shift bits of eight clocks; capture 0001 leaves LSB first
        `CHK(oe_hits, 32);
        `CHK(one_hits, 8);
        `CHK(io_oe_o, 8'h00);
        `CHK(io_pullup_o, 8'hFF);
        `CHK(realtime_prog_active_o, 1'b0);
        `CHK(irq_o, 1'b0);
        rdc(ufg_pkg::OFS_IRQ_STAT, 8'h01);
        wr(ufg_pkg::OFS_IRQ_MASK, 8'h07);
        settle();
        `CHK(irq_o, 1'b1);
        wr(ufg_pkg::OFS_IRQ_STAT, 8'h01);
        settle();
        `CHK(irq_o, 1'b0);
        ufg_host_inst.load_ir(ufg_pkg::IR_PROGRAM);
        ufg_host_inst.load_ir(ufg_pkg::IR_FINISH);
        settle();
        `CHK(program_complete_flag_o, 1'b1);
        `CHK(io_oe_o, uoe);
        `CHK(io_out_o, uout);
        `CHK(io_pullup_o, 8'h00);
        rdc(ufg_pkg::OFS_IRQ_STAT, 8'h02);
        rdc(ufg_pkg::OFS_STAT, 8'h1C);
        // Real-time session: busy, clamp levels, control locked
        wr(ufg_pkg::OFS_IRQ_STAT, 8'h07);
        wr(ufg_pkg::OFS_CTRL, 8'h02);
        wr(ufg_pkg::OFS_CLAMP_VAL, clamp);
        ufg_host_inst.load_ir(ufg_pkg::IR_ENTER);
        settle();
        `CHK(realtime_prog_active_o, 1'b1);
        `CHK(program_complete_flag_o, 1'b0);
        `CHK(io_oe_o, 8'hFF);
        `CHK(io_out_o, clamp);
        `CHK(io_pullup_o, 8'h00);
        wr(ufg_pkg::OFS_CTRL, 8'h00);
        rdc(ufg_pkg::OFS_CTRL, 8'h02);
        // Host wait; user side stays silent while busy
        repeat (WAIT_SIM) @(posedge clock_i);
        ufg_host_inst.load_ir(ufg_pkg::IR_PROGRAM);
        rdc(ufg_pkg::OFS_STAT, 8'h1B);
        ufg_host_inst.load_ir(ufg_pkg::IR_FINISH);
        settle();
        `CHK(realtime_prog_active_o, 1'b0);
        `CHK(program_complete_flag_o, 1'b1);
        `CHK(io_oe_o, uoe);
        // Clamp session broken off by the host on purpose
        wr(ufg_pkg::OFS_IRQ_STAT, 8'h07);
        wr(ufg_pkg::OFS_CTRL, 8'h01);
        clamp = 8'($random(seed));
        wr(ufg_pkg::OFS_CLAMP_VAL, clamp);
        ufg_host_inst.load_ir(ufg_pkg::IR_ENTER);
        settle();
        `CHK(realtime_prog_active_o, 1'b0);
        `CHK(io_oe_o, 8'hFF);
        `CHK(io_out_o, clamp);
        ufg_host_inst.tap_reset();
        settle();
        `CHK(program_complete_flag_o, 1'b0);
        `CHK(io_oe_o, 8'h00);
        rdc(ufg_pkg::OFS_IRQ_STAT, 8'h05);
        // Core up, io down: port live but TDO never driven
        wr(ufg_pkg::OFS_CTRL, 8'h00);
        @(posedge clock_i);
        io_supply_ok_i <= 1'b0;
        oe_hits = 0;
        ufg_host_inst.load_ir(ufg_pkg::IR_ENTER);
        settle();
        `CHK(oe_hits, 0);
        `CHK(io_oe_o, 8'h00);
        rdc(ufg_pkg::OFS_STAT, 8'h09);
        ufg_host_inst.tap_reset();
        // Io up, core down: port inactive, TDO tristate
        @(posedge clock_i);
        io_supply_ok_i <= 1'b1;
        core_supply_ok_i <= 1'b0;
        oe_hits = 0;
        ufg_host_inst.load_ir(ufg_pkg::IR_ENTER);
        settle();
        `CHK(oe_hits, 0);
        rdc(ufg_pkg::OFS_STAT, 8'h10);
        results();
    end
endmodule
